// ---- design/brcs_pkg.sv ----
package brcs_pkg;
  // Configuration space byte offsets
  localparam logic [7:0]  BRCTL_OFS       = 8'h3E;   // Bridge control, upper half of dword
  localparam logic [7:0]  DIAG_OFS        = 8'h41;   // Diagnostic control, byte lane 1
  localparam logic [7:0]  SCLK_OFS        = 8'h68;   // Secondary clock control
  localparam logic [7:0]  PMCSR_OFS       = 8'hE0;   // Power state control
  localparam logic [5:0]  BRCTL_DW        = BRCTL_OFS[7:2];
  localparam logic [5:0]  DIAG_DW         = DIAG_OFS[7:2];
  localparam logic [5:0]  SCLK_DW         = SCLK_OFS[7:2];
  localparam logic [5:0]  PMCSR_DW        = PMCSR_OFS[7:2];
  // Field positions
  localparam int          SBR_BIT         = 6;       // Secondary bus reset in bridge control
  localparam int          CRST_BIT        = 0;       // Chip reset in diagnostic control
  localparam int          MSK_LEN         = 16;      // Serial clock mask length
  localparam int          NCLK            = 10;      // Secondary clock outputs
  localparam int          PAIR_OUTS       = 4;       // Outputs driven by mask bit pairs
  localparam int          SINGLE_BASE     = 4;       // Mask bit = output index + this
  // Reset values
  localparam logic [15:0] BRCTL_RST       = 16'h0000;
  localparam logic [7:0]  DIAG_RST        = 8'h00;
  localparam logic [15:0] MASK_RST        = 16'h0000;
  // Power states
  localparam logic [1:0]  PS_D0           = 2'h0;
  localparam logic [1:0]  PS_D1           = 2'h1;
  localparam logic [1:0]  PS_D2           = 2'h2;
  localparam logic [1:0]  PS_D3HOT        = 2'h3;
  // Timing
  localparam int          CLK_FREQ_MHZ    = 50;
  localparam int          RST_DELAY_US    = 100;
  localparam int          RST_DELAY_CYC   = RST_DELAY_US * CLK_FREQ_MHZ;
  localparam int          DLY_W           = 16;
  localparam logic [4:0]  CHIP_RST_CYC    = 5'h10;   // Below the 20 clock bound
  localparam logic [3:0]  MSK_LAST        = 4'hF;
  // Reset sequencer states
  typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_DELAY, SQ_RUN} brcs_seq_type;
endpackage : brcs_pkg

// ---- design/brcs_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module brcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;  // First stage, read only by second stage
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // Next values
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Register stages
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : brcs_sync

// ---- design/brcs_top.sv ----
`timescale 1ns/1ps
module brcs_top
  import brcs_pkg::*;
#(
  parameter int RST_DLY_CYC = RST_DELAY_CYC  // 100 us in primary clocks
) (
  // Primary clock and logic reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // Pins
  input  wire logic              primary_reset_n,
  input  wire logic              primary_fast_select,
  input  wire logic              secondary_fast_select,
  input  wire logic              clock_stop_permit,
  input  wire logic              clock_mask_serial_in,
  // Configuration access
  input  wire logic              cfg_req,
  input  wire logic              cfg_write,
  input  wire logic [7:0]        cfg_addr,
  input  wire logic [3:0]        cfg_byte_en,
  input  wire logic [31:0]       cfg_wdata,
  output logic                   cfg_ack,
  output logic      [31:0]       cfg_rdata,
  // Secondary side, primary bus drive and status
  output logic      [NCLK-1:0]   sec_clk_out,
  output logic                   secondary_reset_n,
  output logic                   sec_ctl_oe,
  output logic                   sec_ad_drive_low,
  output logic                   pri_bus_oe,
  output logic                   buf_flush,
  output logic                   mask_loading
);
  // Synchronised pins
  logic [4:0]        pin_s;
  logic              prst_n_s, pfast_s, sfast_s, stop_s, msk_s;
  // State
  brcs_seq_type      seq_r, seq_nxt;           // Reset sequencer
  logic [15:0]       brctl_r, brctl_nxt;       // Bridge control
  logic [7:1]        diag_r, diag_nxt;         // Diagnostic control, upper bits
  logic [15:0]       mask_r, mask_nxt;         // Clock disable mask
  logic [1:0]        pstate_r, pstate_nxt;     // Power state
  logic [3:0]        shcnt_r, shcnt_nxt;       // Mask shift count
  logic [DLY_W-1:0]  dly_r, dly_nxt;           // Release delay
  logic [4:0]        crst_r, crst_nxt;         // Chip reset countdown
  logic              ack_nxt;
  logic [31:0]       rdata_nxt;
  logic              base_r, base_nxt;         // Secondary base clock phase
  logic              div_ph_r, div_ph_nxt;     // Divide-by-two phase
  logic [NCLK-1:0]   clk_nxt;
  logic [NCLK-1:0]   dis;                      // Per output disable
  logic              srst_nxt, flush_nxt, crst_act;
  logic              wr, wr_brctl, wr_diag, wr_sclk, wr_pm;
  logic              run_clk, stop_clk;

  localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(RST_DLY_CYC);
  localparam logic [DLY_W-1:0] DLY_ONE  = 16'h0001;

  // Pin synchroniser, reset edges may be asynchronous
  brcs_sync #(.W(5)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       ({primary_reset_n, primary_fast_select, secondary_fast_select,
               clock_stop_permit, clock_mask_serial_in}),
    .q       (pin_s)
  );
  assign {prst_n_s, pfast_s, sfast_s, stop_s, msk_s} = pin_s;

  // Access decode
  assign crst_act = (crst_r != 5'h00);
  assign wr       = cfg_req && cfg_write && !crst_act;
  assign wr_brctl = wr && (cfg_addr[7:2] == BRCTL_DW) && (&cfg_byte_en[3:2]);
  assign wr_diag  = wr && (cfg_addr[7:2] == DIAG_DW) && cfg_byte_en[1];
  assign wr_sclk  = wr && (cfg_addr[7:2] == SCLK_DW) && (&cfg_byte_en[1:0]);
  assign wr_pm    = wr && (cfg_addr[7:2] == PMCSR_DW) && cfg_byte_en[0];

  // Per output mask decode
  genvar gi;
  generate
    for (gi = 0; gi < NCLK; gi++) begin : g_msk
      if (gi < PAIR_OUTS) begin : g_pair
        assign dis[gi] = mask_r[2*gi] | mask_r[2*gi+1];
      end else begin : g_single
        assign dis[gi] = mask_r[gi+SINGLE_BASE];
      end
    end
  endgenerate

  // Registers, sequencer and config answers
  always_comb begin
    seq_nxt    = seq_r;
    brctl_nxt  = brctl_r;
    diag_nxt   = diag_r;
    mask_nxt   = mask_r;
    pstate_nxt = pstate_r;
    shcnt_nxt  = shcnt_r;
    dly_nxt    = dly_r;
    crst_nxt   = crst_r;
    ack_nxt    = cfg_req && !crst_act;
    rdata_nxt  = 32'h0000_0000;
    // Read data, unmapped reads zero
    if (cfg_req && !cfg_write) begin
      case (cfg_addr[7:2])
        BRCTL_DW: rdata_nxt[31:16] = brctl_r;
        DIAG_DW:  rdata_nxt[15:8]  = {diag_r, crst_act};
        SCLK_DW:  rdata_nxt[15:0]  = mask_r;
        PMCSR_DW: rdata_nxt[1:0]   = pstate_r;
        default:  rdata_nxt        = 32'h0000_0000;
      endcase
    end
    // Register writes
    if (wr_brctl) begin
      brctl_nxt = cfg_wdata[31:16];
    end
    if (wr_diag) begin
      diag_nxt = cfg_wdata[15:9];
    end
    if (wr_sclk) begin
      mask_nxt = cfg_wdata[15:0];
    end
    if (wr_pm && (cfg_wdata[1:0] != PS_D1) && (cfg_wdata[1:0] != PS_D2)) begin
      pstate_nxt = cfg_wdata[1:0];
      if (pstate_r == PS_D3HOT && cfg_wdata[1:0] == PS_D0) begin
        // Internal reset without secondary reset
        crst_nxt   = CHIP_RST_CYC;
        brctl_nxt  = BRCTL_RST;
        diag_nxt   = DIAG_RST[7:1];
        mask_nxt   = MASK_RST;
        pstate_nxt = PS_D0;
      end
    end
    // Chip reset request
    if (wr_diag && cfg_wdata[8+CRST_BIT]) begin
      crst_nxt   = CHIP_RST_CYC;
      brctl_nxt  = BRCTL_RST;
      brctl_nxt[SBR_BIT] = 1'b1;
      diag_nxt   = DIAG_RST[7:1];
      mask_nxt   = MASK_RST;
      pstate_nxt = PS_D0;
    end else if (crst_act) begin
      crst_nxt = crst_r - 5'h01;
    end
    // Secondary reset sequencer
    case (seq_r)
      SQ_IDLE: begin
        seq_nxt   = SQ_LOAD;
        shcnt_nxt = 4'h0;
      end
      SQ_LOAD: begin
        if (!(wr_diag && cfg_wdata[8+CRST_BIT])) begin
          mask_nxt[shcnt_r] = msk_s;
          shcnt_nxt = shcnt_r + 4'h1;
          if (shcnt_r == MSK_LAST) begin
            seq_nxt = SQ_DELAY;
            dly_nxt = DLY_LOAD;
          end
        end
      end
      SQ_DELAY: begin
        if (brctl_r[SBR_BIT] || brctl_nxt[SBR_BIT]) begin
          dly_nxt = DLY_LOAD;
        end else if (dly_r == DLY_ONE) begin
          seq_nxt = SQ_RUN;
        end else begin
          dly_nxt = dly_r - DLY_ONE;
        end
      end
      SQ_RUN: begin
        if (brctl_nxt[SBR_BIT]) begin
          seq_nxt = SQ_DELAY;
          dly_nxt = DLY_LOAD;
        end
      end
      default: seq_nxt = SQ_IDLE;
    endcase
    // Chip reset restarts the mask load from any state
    if (wr_diag && cfg_wdata[8+CRST_BIT]) begin
      seq_nxt   = SQ_LOAD;
      shcnt_nxt = 4'h0;
    end
    // Primary reset overrides everything
    if (!prst_n_s) begin
      seq_nxt    = SQ_IDLE;
      brctl_nxt  = BRCTL_RST;
      diag_nxt   = DIAG_RST[7:1];
      mask_nxt   = MASK_RST;
      pstate_nxt = PS_D0;
      crst_nxt   = 5'h00;
      ack_nxt    = 1'b0;
    end
  end

  // Secondary clock generation
  assign run_clk  = prst_n_s && (seq_r != SQ_IDLE);
  assign stop_clk = (pstate_r == PS_D3HOT) && stop_s;
  always_comb begin
    div_ph_nxt = run_clk ? ~div_ph_r : 1'b0;
    base_nxt   = 1'b0;
    if (run_clk) begin
      if (pfast_s && !sfast_s) begin
        base_nxt = div_ph_r ? ~base_r : base_r;
      end else begin
        base_nxt = ~base_r;
      end
    end
    for (int i = 0; i < NCLK; i++) begin
      if (!run_clk || stop_clk) begin
        clk_nxt[i] = 1'b0;
      end else if (dis[i]) begin
        clk_nxt[i] = 1'b1;
      end else begin
        clk_nxt[i] = base_nxt;
      end
    end
  end

  // Pin control from reset state
  always_comb begin
    srst_nxt  = (seq_nxt == SQ_RUN);
    flush_nxt = (secondary_reset_n && !srst_nxt) || (crst_nxt != 5'h00 && !crst_act);
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      seq_r             <= SQ_IDLE;
      brctl_r           <= BRCTL_RST;
      diag_r            <= DIAG_RST[7:1];
      mask_r            <= MASK_RST;
      pstate_r          <= PS_D0;
      shcnt_r           <= 4'h0;
      dly_r             <= '0;
      crst_r            <= 5'h00;
      cfg_ack           <= 1'b0;
      cfg_rdata         <= 32'h0000_0000;
      base_r            <= 1'b0;
      div_ph_r          <= 1'b0;
      sec_clk_out       <= '0;
      secondary_reset_n <= 1'b0;
      sec_ctl_oe        <= 1'b0;
      sec_ad_drive_low  <= 1'b1;
      pri_bus_oe        <= 1'b0;
      buf_flush         <= 1'b0;
      mask_loading      <= 1'b0;
    end else begin
      seq_r             <= seq_nxt;
      brctl_r           <= brctl_nxt;
      diag_r            <= diag_nxt;
      mask_r            <= mask_nxt;
      pstate_r          <= pstate_nxt;
      shcnt_r           <= shcnt_nxt;
      dly_r             <= dly_nxt;
      crst_r            <= crst_nxt;
      cfg_ack           <= ack_nxt;
      cfg_rdata         <= rdata_nxt;
      base_r            <= base_nxt;
      div_ph_r          <= div_ph_nxt;
      sec_clk_out       <= clk_nxt;
      secondary_reset_n <= srst_nxt;
      sec_ctl_oe        <= srst_nxt && (crst_nxt == 5'h00);
      sec_ad_drive_low  <= !srst_nxt;
      pri_bus_oe        <= prst_n_s && (crst_nxt == 5'h00);
      buf_flush         <= flush_nxt;
      mask_loading      <= (seq_nxt == SQ_LOAD);
    end
  end

  // Checks
  sequence s_chip_start;
    $rose(crst_act);
  endsequence
  sequence s_chip_busy;
    crst_act [*8];
  endsequence
  sequence s_pm_low_req;
    wr_pm && (cfg_wdata[1:0] == PS_D1 || cfg_wdata[1:0] == PS_D2);
  endsequence

  a_prst_holds_srst: assert property (@(posedge ref_clk) disable iff (!rstn)
    !prst_n_s |=> !secondary_reset_n)
    else $error("secondary reset not held during primary reset");
  a_sbr_holds_srst: assert property (@(posedge ref_clk) disable iff (!rstn)
    brctl_r[SBR_BIT] |=> !secondary_reset_n)
    else $error("secondary reset released while bit set");
  a_release_delay: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(secondary_reset_n) |-> $past(seq_r) == SQ_DELAY && $past(dly_r) == DLY_ONE)
    else $error("secondary reset released without full delay");
  a_chip_self_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_chip_start |-> s_chip_busy ##[1:12] !crst_act)
    else $error("chip reset did not clear in time");
  a_chip_no_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
    crst_act |=> !cfg_ack)
    else $error("access answered during chip reset");
  a_chip_sets_sbr: assert property (@(posedge ref_clk) disable iff (!rstn)
    (wr_diag && cfg_wdata[8+CRST_BIT] && prst_n_s) |=> brctl_r[SBR_BIT] ##1 !secondary_reset_n)
    else $error("chip reset did not set secondary reset");
  a_srst_bus_state: assert property (@(posedge ref_clk) disable iff (!rstn)
    !secondary_reset_n |-> !sec_ctl_oe && sec_ad_drive_low)
    else $error("secondary bus driven wrongly in reset");
  a_low_state_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_pm_low_req and prst_n_s |=> $stable(pstate_r))
    else $error("D1 or D2 request changed power state");
  a_clk_stopped: assert property (@(posedge ref_clk) disable iff (!rstn)
    stop_clk |=> sec_clk_out == '0)
    else $error("secondary clocks not stopped low");
  a_masked_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    run_clk && !stop_clk && dis[SINGLE_BASE] |=> sec_clk_out[SINGLE_BASE])
    else $error("masked clock not held high");
endmodule : brcs_top

// ---- verification/brcs_mask_src.sv ----
`timescale 1ns/1ps
// Board shift register that feeds the serial clock mask
module brcs_mask_src (
  // Clock
  input  wire logic ref_clk,
  // Load window and mask level chosen by the bench
  input  wire logic load_en,
  input  wire logic fill,
  // Serial mask line
  output logic      clock_mask_serial_in
);
  logic alt_r = 1'b0;  // Changing filler outside the load window

  // Line holds no stale value once the register stops shifting
  always_ff @(posedge ref_clk) begin
    alt_r <= ~alt_r;
  end

  // Uniform mask level while loading, ones disable unused outputs
  assign clock_mask_serial_in = load_en ? fill : alt_r;
endmodule : brcs_mask_src

// ---- verification/test_bridge_reset_clock_sequencer.sv ----
`timescale 1ns/1ps
module test_bridge_reset_clock_sequencer import brcs_pkg::*;;
  localparam int RDLY = 20;           // Shortened release delay
  logic          ref_clk, rstn, prn;  // Clock, logic reset, primary reset pin
  logic          pfs, sfs, csp, msi;  // Speed selects, stop permit, mask line
  logic          req, wr, ack;        // Config handshake
  logic [7:0]    addr;                // Config byte address
  logic [3:0]    be;                  // Byte enables
  logic [31:0]   wd, rdat, rd;        // Write data, read data, last read
  logic [9:0]    sclk, ah, oh;        // Clocks, AND and OR of samples
  logic          srn, ctl_oe, ad_low; // Secondary reset and bus drive
  logic          pri_oe, flush, ldg;  // Primary drive, flush, mask loading
  logic          load_en, fill, fl, sl;
  int            num_errors, n_compared, tg, n;

  brcs_top #(.RST_DLY_CYC(RDLY)) i_brcs_top (
    .ref_clk(ref_clk), .rstn(rstn), .primary_reset_n(prn),
    .primary_fast_select(pfs), .secondary_fast_select(sfs),
    .clock_stop_permit(csp), .clock_mask_serial_in(msi),
    .cfg_req(req), .cfg_write(wr), .cfg_addr(addr), .cfg_byte_en(be),
    .cfg_wdata(wd), .cfg_ack(ack), .cfg_rdata(rdat), .sec_clk_out(sclk),
    .secondary_reset_n(srn), .sec_ctl_oe(ctl_oe), .sec_ad_drive_low(ad_low),
    .pri_bus_oe(pri_oe), .buf_flush(flush), .mask_loading(ldg));

  brcs_mask_src i_brcs_mask_src (
    .ref_clk(ref_clk), .load_en(load_en), .fill(fill), .clock_mask_serial_in(msi));

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Wait k edges, then settle
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  // One config access, answer looked at just after the taking edge
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, input logic ea);
    cyc(1);
    {req, wr, addr, be, wd} = {1'b1, w, a, b, d};
    cyc(1);
    req = 1'b0;
    rd  = rdat;
    chk("cfg_ack", {31'h0, ack}, {31'h0, ea});
  endtask : cfg

  // Sample the clock outputs over eight intervals
  task automatic clk_run();
    logic [9:0] p;
    ah = 10'h3FF;
    oh = 10'h000;
    tg = 0;
    p  = sclk;
    repeat (8) begin
      cyc(1);
      ah &= sclk & p;
      oh |= sclk | p;
      tg += int'(sclk[1] != p[1]);
      p = sclk;
    end
  endtask : clk_run

  // Bounded wait for secondary reset release
  task automatic wait_rel();
    for (n = 0; n < 3 * RDLY && srn !== 1'b1; n++) cyc(1);
  endtask : wait_rel

  // Verdict
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Watchdog
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    results();
  end

  // Main sequence
  initial begin
    {rstn, prn, pfs, sfs, csp, req, wr, addr, be, wd} = '0;
    {num_errors, n_compared} = '0;
    {load_en, fill} = 2'b11;
    repeat (20) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    cyc(3);
    chk("srn held", srn, 0);
    chk("clk idle", sclk, 0);
    chk("pri float", pri_oe, 0);
    chk("ad low", ad_low, 1);
    cfg(0, 8'h3C, 4'hF, 0, 0);
    prn = 1'b1;
    for (n = 0; n < 10 && ldg !== 1'b1; n++) cyc(1);
    for (n = 0; n < 40 && ldg === 1'b1; n++) cyc(1);
    chk("load len", n, 16);
    load_en = 1'b0;
    wait_rel();
    chk("rel win", n >= RDLY - 1 && n <= RDLY + 1, 1);
    chk("bus on", pri_oe, 1);
    clk_run();
    chk("mask ones", ah, 10'h3FF);
    cfg(1, SCLK_OFS, 4'h3, 32'h0000_6142, 1);
    clk_run();
    chk("mask pairs", ah, 10'h219);
    $display("test mask done");
    for (int i = 0; i < 4; i++) begin
      {pfs, sfs} = 2'(i);
      cyc(4);
      clk_run();
      chk("toggles", tg, (i == 2) ? 4 : 8);
      chk("all out", oh, 10'h3FF);
    end
    $display("test speed done");
    cfg(1, 8'h3C, 4'hC, 32'h0040_0000, 1);
    chk("sbr rst", srn, 0);
    chk("ctl float", ctl_oe, 0);
    chk("ad low", ad_low, 1);
    chk("flush", flush, 1);
    cfg(0, 8'h3C, 4'hF, 0, 1);
    chk("sbr read", rd & 32'hFFFF_0000, 32'h0040_0000);
    cfg(1, 8'h3C, 4'hC, 0, 1);
    wait_rel();
    chk("sbr delay", n, RDLY);
    chk("ctl on", ctl_oe, 1);
    chk("ad free", ad_low, 0);
    $display("test secondary reset done");
    {load_en, fill} = 2'b10;
    cfg(1, 8'h40, 4'h2, 32'h0000_0100, 1);
    chk("crst srn", srn, 0);
    chk("crst load", ldg, 1);
    cfg(0, 8'h40, 4'hF, 0, 0);
    chk("crst float", pri_oe, 0);
    cyc(16);
    cfg(0, 8'h40, 4'h2, 0, 1);
    chk("crst clear", rd[8], 0);
    cfg(0, 8'h3C, 4'hF, 0, 1);
    chk("sbr set", rd[22], 1);
    cyc(2 * RDLY + 20);
    chk("hold rst", srn, 0);
    load_en = 1'b0;
    cfg(1, 8'h3C, 4'hC, 0, 1);
    wait_rel();
    chk("crst rel", n, RDLY);
    clk_run();
    chk("mask reset", ah, 0);
    $display("test chip reset done");
    cfg(1, SCLK_OFS, 4'h3, 32'h0000_0002, 1);
    for (int i = 1; i < 3; i++) begin
      cfg(1, PMCSR_OFS, 4'h1, i, 1);
      cfg(0, PMCSR_OFS, 4'hF, 0, 1);
      chk("pstate", rd[1:0], PS_D0);
    end
    csp = 1'b1;
    cfg(1, PMCSR_OFS, 4'h1, 32'h0000_0003, 1);
    cyc(4);
    clk_run();
    chk("stopped", oh, 0);
    cfg(1, PMCSR_OFS, 4'h1, 0, 1);
    {fl, sl} = 2'b00;
    repeat (30) begin
      fl |= flush;
      sl |= ~srn;
      cyc(1);
    end
    chk("d0 flush", fl, 1);
    chk("no srn", sl, 0);
    clk_run();
    chk("d0 clocks", {ah, oh}, {10'h000, 10'h3FF});
    $display("test power done");
    prn = 1'b0;
    cyc(4);
    chk("prst srn", srn, 0);
    chk("prst clk", sclk, 0);
    cfg(0, 8'h3C, 4'hF, 0, 0);
    $display("test primary reset done");
    results();
  end
endmodule : test_bridge_reset_clock_sequencer
